// ---- core/csi_status_irq.sv ----
// Status registers, sticky latches and interrupt pin of the clock conditioner
`timescale 1ns/1ns
`include "csi_regs.svh"
// Functional notes
// - Synth lock-loss enable bit 5 gates interrupt
// - Jitter lock-loss enable bit 4 gates interrupt
// - Input LOS enables bits 1 and 0
// - Reference sticky change interrupts when enabled
// - Holdover entry interrupts when enabled
// - Disabled enables still latch, no interrupt
// - Synth lock sticky, active low, W1C
// - Jitter lock sticky, active low, W1C
// - Input LOS stickies, active low, W1C
// - Live register shows selected input
// - Live synth lock bit feeds sticky
// - Live jitter lock bit feeds sticky
// - Live input activity bits feed stickies
// - Reference sticky reads lost since clear
// - Holdover sticky reads entry since clear
// - Calibration busy bit reads live
// - Live reference presence feeds sticky
// - Live holdover bit reads live
// - Lock pin masks jitter condition when set
module csi_status_irq
    import csi_pkg::*;
(
    input  wire logic         ref_clk,
    input  wire logic         nrst,
    input  wire csi_req_type  req,
    input  wire csi_live_type live,
    output logic [7:0]        rdata_ff,
    output logic              interrupt_out_n,
    output logic              lockPin
);
    //==========================================================
    // Enable registers
    logic [7:0] lossIeFf;
    logic [7:0] refHoldIeFf;
    logic       lockMaskFf;
    logic       refStickyPrevFf;
    logic       refEdgePendFf;
    logic       refClearFf;
    logic       intNFf;
    wire logic  wrLossIe;
    wire logic  wrRefHoldIe;
    wire logic  wrLockSticky;
    wire logic  wrRefSticky;
    wire logic  wrLockCfg;
    // Address decode
    assign wrLossIe     = req.wrStb && (req.addr == `CSI_ADDR_LOSS_IE);
    assign wrRefHoldIe  = req.wrStb && (req.addr == `CSI_ADDR_REFHOLD_IE);
    assign wrLockSticky = req.wrStb && (req.addr == `CSI_ADDR_LOCK_STICKY);
    assign wrRefSticky  = req.wrStb && (req.addr == `CSI_ADDR_REF_STICKY);
    assign wrLockCfg    = req.wrStb && (req.addr == `CSI_ADDR_LOCK_PIN_CFG);
    wire logic synth_pll_lockloss_irq_en  = lossIeFf[`CSI_BIT_SYNTH];
    wire logic jitter_pll_lockloss_irq_en = lossIeFf[`CSI_BIT_JITTER];
    wire logic input1_los_irq_en          = lossIeFf[`CSI_BIT_IN1];
    wire logic input0_los_irq_en          = lossIeFf[`CSI_BIT_IN0];
    wire logic ref_status_irq_en          = refHoldIeFf[`CSI_BIT_REF];
    wire logic holdover_irq_en            = refHoldIeFf[`CSI_BIT_HOLD];
    // Only documented enable bits are kept; reserved bits read zero
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            lossIeFf    <= `CSI_IE_RESET;
            refHoldIeFf <= `CSI_IE_RESET;
            lockMaskFf  <= 1'b0;
        end else begin
            if (wrLossIe) begin
                lossIeFf <= req.wdata & `CSI_LOSS_IE_MASK;
            end
            if (wrRefHoldIe) begin
                refHoldIeFf <= req.wdata & `CSI_REFHOLD_IE_MASK;
            end
            if (wrLockCfg) begin
                lockMaskFf <= req.wdata[0];
            end
        end
    end
    //==========================================================
    // Sticky latches, fed by the live bits
    wire logic synth_pll_lock_sticky_n;
    wire logic jitter_pll_lock_sticky_n;
    wire logic input1_active_sticky;
    wire logic input0_active_sticky;
    wire logic ref_present_sticky;
    wire logic holdover_sticky_n;
    csi_sticky_bit uSynth (
        .ref_clk    (ref_clk),
        .nrst       (nrst),
        .event_i    (!live.synthLockLive_n),
        .clear_i    (wrLockSticky && req.wdata[`CSI_BIT_SYNTH]),
        .latch_n_ff (synth_pll_lock_sticky_n)
    );
    csi_sticky_bit uJitter (
        .ref_clk    (ref_clk),
        .nrst       (nrst),
        .event_i    (!live.jitterLockLive_n),
        .clear_i    (wrLockSticky && req.wdata[`CSI_BIT_JITTER]),
        .latch_n_ff (jitter_pll_lock_sticky_n)
    );
    csi_sticky_bit uIn1 (
        .ref_clk    (ref_clk),
        .nrst       (nrst),
        .event_i    (!live.input1ActiveLive),
        .clear_i    (wrLockSticky && req.wdata[`CSI_BIT_IN1]),
        .latch_n_ff (input1_active_sticky)
    );
    csi_sticky_bit uIn0 (
        .ref_clk    (ref_clk),
        .nrst       (nrst),
        .event_i    (!live.input0ActiveLive),
        .clear_i    (wrLockSticky && req.wdata[`CSI_BIT_IN0]),
        .latch_n_ff (input0_active_sticky)
    );
    csi_sticky_bit uRef (
        .ref_clk    (ref_clk),
        .nrst       (nrst),
        .event_i    (!live.refPresentLive),
        .clear_i    (wrRefSticky && req.wdata[`CSI_BIT_REF]),
        .latch_n_ff (ref_present_sticky)
    );
    csi_sticky_bit uHold (
        .ref_clk    (ref_clk),
        .nrst       (nrst),
        .event_i    (!live.holdoverLive_n),
        .clear_i    (wrRefSticky && req.wdata[`CSI_BIT_HOLD]),
        .latch_n_ff (holdover_sticky_n)
    );
    //==========================================================
    // Reference sticky change tracking; either direction is an event.
    // The rise that a software clear itself causes is not a new change,
    // otherwise every clear would re-arm the interrupt it just cleared.
    wire logic refClearWr = wrRefSticky && req.wdata[`CSI_BIT_REF];
    wire logic refChanged = (ref_present_sticky != refStickyPrevFf) &&
                            !(refClearFf && ref_present_sticky);
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            refStickyPrevFf <= `CSI_STICKY_RESET;
            refEdgePendFf   <= 1'b0;
            refClearFf      <= 1'b0;
        end else begin
            refStickyPrevFf <= ref_present_sticky;
            refClearFf      <= refClearWr;
            if (refChanged) begin
                refEdgePendFf <= 1'b1;
            end else if (refClearWr) begin
                refEdgePendFf <= 1'b0;
            end
        end
    end
    //==========================================================
    // Interrupt combine; disabled sources latch but stay silent
    wire logic irqAny =
        (synth_pll_lockloss_irq_en  && !synth_pll_lock_sticky_n)  ||
        (jitter_pll_lockloss_irq_en && !jitter_pll_lock_sticky_n) ||
        (input1_los_irq_en          && !input1_active_sticky)     ||
        (input0_los_irq_en          && !input0_active_sticky)     ||
        (ref_status_irq_en          && refEdgePendFf)             ||
        (holdover_irq_en            && !holdover_sticky_n);
    // Level output: low while anything enabled is pending
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            intNFf <= 1'b1;
        end else begin
            intNFf <= !irqAny;
        end
    end
    assign interrupt_out_n = intNFf;
    //==========================================================
    // Read data mux, registered; unmapped addresses read zero
    wire logic [7:0] lockSticky = {2'b00, synth_pll_lock_sticky_n, jitter_pll_lock_sticky_n,
                                   2'b00, input1_active_sticky, input0_active_sticky};
    wire logic [7:0] lockLive   = {live.selectedInput, live.synthLockLive_n,
                                   live.jitterLockLive_n, 2'b00,
                                   live.input1ActiveLive, live.input0ActiveLive};
    wire logic [7:0] refSticky  = {6'b000000, ref_present_sticky, holdover_sticky_n};
    wire logic [7:0] refLive    = {5'b00000, live.synthCalBusy,
                                   live.refPresentLive, live.holdoverLive_n};
    logic [7:0] rdMux;
    always_comb begin
        unique case (req.addr)
            `CSI_ADDR_LOSS_IE:      rdMux = lossIeFf;
            `CSI_ADDR_REFHOLD_IE:   rdMux = refHoldIeFf;
            `CSI_ADDR_LOCK_STICKY:  rdMux = lockSticky;
            `CSI_ADDR_LOCK_LIVE:    rdMux = lockLive;
            `CSI_ADDR_REF_STICKY:   rdMux = refSticky;
            `CSI_ADDR_REF_LIVE:     rdMux = refLive;
            `CSI_ADDR_LOCK_PIN_CFG: rdMux = {7'b0000000, lockMaskFf};
            default:                rdMux = `CSI_ZERO_BYTE;
        endcase
    end
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_ff <= `CSI_ZERO_BYTE;
        end else if (req.rdStb) begin
            rdata_ff <= rdMux;
        end
    end
    //==========================================================
    // Lock pin
    csi_lock_pin uLockPin (
        .ref_clk              (ref_clk),
        .nrst                 (nrst),
        .synthLock_n          (live.synthLockLive_n),
        .jitterLock_n         (live.jitterLockLive_n),
        .jitter_lock_pin_mask (lockMaskFf),
        .lockPin_ff           (lockPin)
    );
    //==========================================================
    // Assertions
    sequence s_synth_loss;
        !live.synthLockLive_n;
    endsequence
    // Event steps: live loss, then sticky one edge later, then the pin
    sequence s_jitter_loss;
        !live.jitterLockLive_n;
    endsequence
    sequence s_in1_loss;
        !live.input1ActiveLive;
    endsequence
    sequence s_in0_loss;
        !live.input0ActiveLive;
    endsequence
    sequence s_hold_entry;
        !live.holdoverLive_n;
    endsequence
    sequence s_ref_loss;
        !live.refPresentLive;
    endsequence
    a_synth_latch_set: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_synth_loss |=> !synth_pll_lock_sticky_n)
        else $error("synth sticky not set");
    a_jitter_irq_path: assert property (@(posedge ref_clk) disable iff (!nrst)
        (s_jitter_loss and (jitter_pll_lockloss_irq_en && !wrLossIe))
        |=> ##1 !interrupt_out_n)
        else $error("jitter loss gave no interrupt");
    a_synth_irq_path: assert property (@(posedge ref_clk) disable iff (!nrst)
        (s_synth_loss and (synth_pll_lockloss_irq_en && !wrLossIe))
        |=> ##1 !interrupt_out_n)
        else $error("synth loss gave no interrupt");
    a_in0_latch_set: assert property (@(posedge ref_clk) disable iff (!nrst)
        !live.input0ActiveLive |=> !input0_active_sticky)
        else $error("input0 sticky not set");
    a_clear_works: assert property (@(posedge ref_clk) disable iff (!nrst)
        (wrLockSticky && req.wdata[`CSI_BIT_JITTER] && live.jitterLockLive_n)
        |=> jitter_pll_lock_sticky_n)
        else $error("jitter sticky not cleared");
    a_hold_latch_set: assert property (@(posedge ref_clk) disable iff (!nrst)
        !live.holdoverLive_n |=> !holdover_sticky_n)
        else $error("holdover sticky not set");
    a_irq_quiet_off: assert property (@(posedge ref_clk) disable iff (!nrst)
        (lossIeFf == `CSI_IE_RESET && refHoldIeFf == `CSI_IE_RESET) |=> interrupt_out_n)
        else $error("interrupt with all enables off");
    a_ref_edge_irq: assert property (@(posedge ref_clk) disable iff (!nrst)
        (refChanged && ref_status_irq_en && !wrRefHoldIe)
        |=> ##1 !interrupt_out_n)
        else $error("reference change gave no interrupt");
    a_irq_holds: assert property (@(posedge ref_clk) disable iff (!nrst)
        (holdover_irq_en && !holdover_sticky_n && !wrRefSticky && !wrRefHoldIe)
        |=> ##1 !interrupt_out_n)
        else $error("interrupt released while pending");
    a_jitter_latch_set: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_jitter_loss |=> !jitter_pll_lock_sticky_n)
        else $error("jitter sticky not set");
    a_in1_latch_set: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_in1_loss |=> !input1_active_sticky)
        else $error("input1 sticky not set");
    a_ref_latch_set: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_ref_loss |=> !ref_present_sticky)
        else $error("reference sticky not set");
    a_in1_irq_path: assert property (@(posedge ref_clk) disable iff (!nrst)
        (s_in1_loss and (input1_los_irq_en && !wrLossIe))
        |=> ##1 !interrupt_out_n)
        else $error("input1 loss gave no interrupt");
    a_in0_irq_path: assert property (@(posedge ref_clk) disable iff (!nrst)
        (s_in0_loss and (input0_los_irq_en && !wrLossIe))
        |=> ##1 !interrupt_out_n)
        else $error("input0 loss gave no interrupt");
    a_hold_irq_path: assert property (@(posedge ref_clk) disable iff (!nrst)
        (s_hold_entry and (holdover_irq_en && !wrRefHoldIe))
        |=> ##1 !interrupt_out_n)
        else $error("holdover entry gave no interrupt");
    a_ref_pend_set: assert property (@(posedge ref_clk) disable iff (!nrst)
        refChanged |=> refEdgePendFf)
        else $error("reference change not pending");
    a_ref_clear_quiet: assert property (@(posedge ref_clk) disable iff (!nrst)
        (refClearWr && !refChanged && live.refPresentLive)
        |=> !refEdgePendFf ##1 !refEdgePendFf)
        else $error("reference clear re-armed its interrupt");
    //==========================================================
    // Read-back of live fields, one edge after the strobe
    sequence s_rd_lock_live;
        req.rdStb && (req.addr == `CSI_ADDR_LOCK_LIVE);
    endsequence
    sequence s_rd_ref_live;
        req.rdStb && (req.addr == `CSI_ADDR_REF_LIVE);
    endsequence
    a_sel_read_back: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_rd_lock_live
        |=> (rdata_ff[`CSI_SEL_LSB +: 2] == $past(live.selectedInput)))
        else $error("selected input misread");
    a_cal_read_back: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_rd_ref_live
        |=> (rdata_ff[`CSI_BIT_CAL] == $past(live.synthCalBusy)))
        else $error("calibration busy misread");
    a_hold_read_back: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_rd_ref_live
        |=> (rdata_ff[`CSI_BIT_HOLD] == $past(live.holdoverLive_n)))
        else $error("live holdover misread");
endmodule : csi_status_irq

// ---- core/csi_regs.svh ----
// Register offsets, field positions and reset values of the clock status interrupt logic
`ifndef CSI_REGS_SVH
`define CSI_REGS_SVH
`define CSI_ADDR_LOSS_IE      8'h68
`define CSI_ADDR_REFHOLD_IE   8'h69
`define CSI_ADDR_LOCK_STICKY  8'h6C
`define CSI_ADDR_LOCK_LIVE    8'h6D
`define CSI_ADDR_REF_STICKY   8'h6E
`define CSI_ADDR_REF_LIVE     8'h6F
`define CSI_ADDR_LOCK_PIN_CFG 8'h70
`define CSI_BIT_SYNTH         5
`define CSI_BIT_JITTER        4
`define CSI_BIT_IN1           1
`define CSI_BIT_IN0           0
`define CSI_BIT_REF           1
`define CSI_BIT_HOLD          0
`define CSI_BIT_CAL           2
`define CSI_SEL_LSB           6
`define CSI_IE_RESET          8'h00
`define CSI_STICKY_RESET      1'b1
`define CSI_ZERO_BYTE         8'h00
`define CSI_LOSS_IE_MASK      8'h33
`define CSI_REFHOLD_IE_MASK   8'h03
`endif

// ---- core/csi_pkg.sv ----
// Types shared by the clock status interrupt logic
package csi_pkg;
    // Live conditions from the PLLs, detectors and the selection machine
    typedef struct packed {
        logic [1:0] selectedInput;
        logic       synthLockLive_n;
        logic       jitterLockLive_n;
        logic       input1ActiveLive;
        logic       input0ActiveLive;
        logic       refPresentLive;
        logic       holdoverLive_n;
        logic       synthCalBusy;
    } csi_live_type;
    // One register access from the serial configuration port
    typedef struct packed {
        logic       wrStb;
        logic       rdStb;
        logic [7:0] addr;
        logic [7:0] wdata;
    } csi_req_type;
    typedef enum logic [1:0] {
        CSI_LP_IDLE = 2'b00,
        CSI_LP_LOST = 2'b01
    } csi_lp_type;
endpackage : csi_pkg

// ---- core/csi_sticky_bit.sv ----
// One sticky status latch, reads 0 once its event has been seen
`timescale 1ns/1ns
`include "csi_regs.svh"
module csi_sticky_bit (
    input  wire logic ref_clk,
    input  wire logic nrst,
    input  wire logic event_i,
    input  wire logic clear_i,
    output logic      latch_n_ff
);
    // Event wins over a same-cycle clear so nothing is lost
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            latch_n_ff <= `CSI_STICKY_RESET;
        end else if (event_i) begin
            latch_n_ff <= 1'b0;
        end else if (clear_i) begin
            latch_n_ff <= 1'b1;
        end
    end
endmodule : csi_sticky_bit

// ---- core/csi_lock_pin.sv ----
// Lock output pin driver with jitter-lock masking
`timescale 1ns/1ns
module csi_lock_pin
    import csi_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic nrst,
    input  wire logic synthLock_n,
    input  wire logic jitterLock_n,
    input  wire logic jitter_lock_pin_mask,
    output logic      lockPin_ff
);
    wire logic  lost;
    // Masked condition cannot pull the pin down
    assign lost = !synthLock_n || (!jitterLock_n && !jitter_lock_pin_mask);
    // Pin shows unlocked out of reset until the first clean edge
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            lockPin_ff <= 1'b0;
        end else begin
            lockPin_ff <= !lost;
        end
    end
    a_lock_pin_mask: assert property (@(posedge ref_clk) disable iff (!nrst)
        (jitter_lock_pin_mask && synthLock_n) |=> lockPin_ff)
        else $error("lock pin low from masked jitter condition");
    a_lock_pin_show: assert property (@(posedge ref_clk) disable iff (!nrst)
        (!jitter_lock_pin_mask && !jitterLock_n) |=> !lockPin_ff)
        else $error("lock pin missed jitter lock loss");
endmodule : csi_lock_pin

// ---- bench/csi_testbench.sv ----
// Self-checking testbench of the clock status interrupt logic
`timescale 1ns/1ns
`include "csi_regs.svh"
module testbench
    import csi_pkg::*;
;
    // ==========================================================
    // Signals
    // ==========================================================
    localparam logic [8:0] GOOD_LIVE = 9'h07E; // Locked, both inputs active, no holdover
    logic          ref_clk;
    logic          nrst;
    csi_req_type   req;
    csi_live_type  live;
    logic [7:0]    rdata;
    logic          intN;
    logic          lockPin;
    logic          mask;
    logic [9:0]    expQ[$];     // Notes of {interrupt, lock pin, read data}
    int            errCount;
    int            totalChecks;
    int            cycles;
    integer        seed;
    logic [8:0]    flip[6]    = '{9'h040, 9'h020, 9'h010, 9'h008, 9'h004, 9'h002};
    logic [7:0]    stReg[6]   = '{8'h6C, 8'h6C, 8'h6C, 8'h6C, 8'h6E, 8'h6E};
    logic [7:0]    enReg[6]   = '{8'h68, 8'h68, 8'h68, 8'h68, 8'h69, 8'h69};
    logic [7:0]    bitVal[6]  = '{8'h20, 8'h10, 8'h02, 8'h01, 8'h02, 8'h01};

    csi_status_irq uut (
        .ref_clk         (ref_clk),
        .nrst            (nrst),
        .req             (req),
        .live            (live),
        .rdata_ff        (rdata),
        .interrupt_out_n (intN),
        .lockPin         (lockPin)
    );

    // ==========================================================
    // Clock, timeout and closing report
    // ==========================================================
    always #2 ref_clk = ~ref_clk;

    // A hang is cut short well above the few hundred cycles the run needs
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errCount++;
            summarize();
        end
    end

    task summarize();
        $display("checks %0d errors %0d", totalChecks, errCount);
        if (errCount == 0 && totalChecks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : summarize

    task check(input logic [9:0] seen, input logic [9:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            errCount++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // ==========================================================
    // Driver tasks, all changes at the falling edge
    // ==========================================================
    function automatic logic [7:0] liveA();
        return {live.selectedInput, live.synthLockLive_n, live.jitterLockLive_n, 2'b00,
                live.input1ActiveLive, live.input0ActiveLive};
    endfunction : liveA

    function automatic logic [7:0] liveB();
        return {5'h00, live.synthCalBusy, live.refPresentLive, live.holdoverLive_n};
    endfunction : liveB

    task idle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : idle

    // Idle cycles after a change let sticky, interrupt and lock pin settle
    task setLive(input logic [8:0] v);
        @(negedge ref_clk);
        live = v;
        idle(3);
    endtask : setLive

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        req = '{1'b1, 1'b0, a, d};
        @(negedge ref_clk);
        req.wrStb = 1'b0;
        idle(2);
    endtask : wr

    // Lock pin expectation: low if either PLL lost, jitter loss hidden by the mask
    task rd(input logic [7:0] a, input logic [7:0] d, input logic intE);
        @(negedge ref_clk);
        req.rdStb = 1'b1;
        req.addr  = a;
        expQ.push_back({intE, live.synthLockLive_n & (live.jitterLockLive_n | mask), d});
        @(negedge ref_clk);
        req.rdStb = 1'b0;
    endtask : rd

    // ==========================================================
    // Monitor: read data lands one edge after the strobe
    // ==========================================================
    always @(posedge ref_clk) begin
        if (nrst === 1'b1 && req.rdStb === 1'b1) begin
            @(negedge ref_clk);
            if (expQ.size() == 0)
                check(10'h3FF, 10'h000);
            else
                check({intN, lockPin, rdata}, expQ.pop_front());
        end
    end

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        logic [8:0] v;
        ref_clk = 1'b0;
        nrst = 1'b0;
        req = '0;
        live = GOOD_LIVE;
        mask = 1'b0;
        seed = 32'h8D04;
        errCount = 0;
        totalChecks = 0;
        cycles = 0;
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        nrst = 1'b1;
        // Reset values, reserved bits and unmapped places
        rd(`CSI_ADDR_LOSS_IE, 8'h00, 1'b1);
        rd(`CSI_ADDR_REFHOLD_IE, 8'h00, 1'b1);
        rd(`CSI_ADDR_LOCK_STICKY, 8'h33, 1'b1);
        rd(`CSI_ADDR_REF_STICKY, 8'h03, 1'b1);
        wr(`CSI_ADDR_LOSS_IE, 8'hFF);
        rd(`CSI_ADDR_LOSS_IE, 8'h33, 1'b1);
        wr(`CSI_ADDR_LOSS_IE, 8'h00);
        wr(`CSI_ADDR_LOCK_LIVE, 8'hFF);
        rd(`CSI_ADDR_LOCK_LIVE, liveA(), 1'b1);
        wr(8'h6A, 8'hFF);
        rd(8'h6A, 8'h00, 1'b1);
        // Random live conditions and lock pin mask
        for (int i = 0; i < 12; i++) begin
            v = 9'($random(seed));
            v[8] = 1'b0;
            mask = 1'($random(seed));
            wr(`CSI_ADDR_LOCK_PIN_CFG, {7'h00, mask});
            setLive(v);
            rd(`CSI_ADDR_LOCK_LIVE, liveA(), 1'b1);
            rd(`CSI_ADDR_REF_LIVE, liveB(), 1'b1);
        end
        // Masked jitter loss alone leaves the lock pin high
        mask = 1'b1;
        wr(`CSI_ADDR_LOCK_PIN_CFG, 8'h01);
        setLive(GOOD_LIVE ^ 9'h020);
        rd(`CSI_ADDR_LOCK_LIVE, liveA(), 1'b1);
        mask = 1'b0;
        wr(`CSI_ADDR_LOCK_PIN_CFG, 8'h00);
        setLive(GOOD_LIVE);
        wr(`CSI_ADDR_LOCK_STICKY, 8'hFF);
        wr(`CSI_ADDR_REF_STICKY, 8'hFF);
        // Each condition: latched while disabled, interrupts once enabled, cleared by 1
        for (int i = 0; i < 6; i++) begin
            v = (stReg[i] == 8'h6C) ? 9'h033 : 9'h003;
            setLive(GOOD_LIVE ^ flip[i]);
            setLive(GOOD_LIVE);
            rd(stReg[i], v[7:0] & ~bitVal[i], 1'b1);
            wr(enReg[i], bitVal[i]);
            rd(stReg[i], v[7:0] & ~bitVal[i], 1'b0);
            if (i == 4) begin
                // Disabling hides the pending reference change
                wr(enReg[i], 8'h00);
                rd(stReg[i], v[7:0] & ~bitVal[i], 1'b1);
                wr(stReg[i], bitVal[i]);
                rd(stReg[i], v[7:0], 1'b1);
            end else begin
                wr(stReg[i], bitVal[i]);
                rd(stReg[i], v[7:0], 1'b1);
                wr(enReg[i], 8'h00);
            end
        end
        // Every condition at once, all enabled; clearing releases the pin for good
        wr(`CSI_ADDR_LOSS_IE, 8'h33);
        wr(`CSI_ADDR_REFHOLD_IE, 8'h03);
        setLive(GOOD_LIVE ^ 9'h07E);
        setLive(GOOD_LIVE);
        rd(`CSI_ADDR_LOCK_STICKY, 8'h00, 1'b0);
        rd(`CSI_ADDR_REF_STICKY, 8'h00, 1'b0);
        wr(`CSI_ADDR_LOCK_STICKY, 8'h33);
        wr(`CSI_ADDR_REF_STICKY, 8'h03);
        rd(`CSI_ADDR_REF_STICKY, 8'h03, 1'b1);
        wr(`CSI_ADDR_REFHOLD_IE, 8'h00);
        // Two pendings: clear during a live fault keeps the latch, pin waits for both
        wr(`CSI_ADDR_LOSS_IE, 8'h30);
        setLive(GOOD_LIVE ^ 9'h060);
        wr(`CSI_ADDR_LOCK_STICKY, 8'h30);
        rd(`CSI_ADDR_LOCK_STICKY, 8'h03, 1'b0);
        setLive(GOOD_LIVE);
        wr(`CSI_ADDR_LOCK_STICKY, 8'h20);
        rd(`CSI_ADDR_LOCK_STICKY, 8'h23, 1'b0);
        wr(`CSI_ADDR_LOCK_STICKY, 8'h10);
        rd(`CSI_ADDR_LOCK_STICKY, 8'h33, 1'b1);
        idle(3);
        if (expQ.size() != 0)
            check(10'h3FF, 10'h000);
        summarize();
    end
endmodule : testbench
